// ===== rtl/ips_audio_port.sv
// serial audio port: divider, framing, serializers, buffers, flags
// Contract
// - one bit per SCK, MSB first
// - word select low left, high right
// - word select changes one bit early
// - master drives SCK and WS, slave receives
// - link runs only when enabled; else mu-law
// - buffer refill sets transmit done flags
// - high data write clears transmit done
// - transmit irq needs both enables
// - full receive buffer copied, flags set
// - high data read clears receive done
// - receive irq needs both enables
// - software-set flags raise enabled irqs
// - DMA triggers pulse on done events
// - empty transmit buffer resends stale, underflow
// - full receive buffer overwritten, overflow
// - error flags cleared only by software
// - stereo channel side status bits
// - role select one means master
// - fractional divider dividend over divisor
// - divider fields split across three registers
// - role select zero means slave
// - master word size minus one, pad/truncate
`timescale 1ns/10ps
`default_nettype none

module ips_fifo2 #(
    parameter int W = 17,
    parameter int DEPTH = 2
) (
    input wire logic clk, // system clock
    input wire logic sysRst, // synchronous reset
    input wire logic inValid, // word offered
    output logic inReady, // room, or a pop this cycle
    input wire logic inForce, // overwrite newest when full
    input wire logic [W-1:0] inData, // word in
    output logic outValid, // word available
    input wire logic outReady, // consumer takes word
    output logic [W-1:0] outData // oldest word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] rdPtr, wrPtr, next_rdPtr, next_wrPtr;
    logic [CW-1:0] count, next_count;
    logic pop, push, over;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    always_comb begin
        outValid = count != '0;
        outData = mem[rdPtr];
        pop = outValid && outReady;
        inReady = (count != CW'(DEPTH)) || pop;
        push = inValid && inReady;
        over = inValid && !inReady && inForce;
        next_rdPtr = pop ? bump(rdPtr) : rdPtr;
        next_wrPtr = push ? bump(wrPtr) : wrPtr;
        next_count = CW'(count + CW'(push) - CW'(pop));
    end

    always_ff @(posedge clk) begin
        if (sysRst) begin
            rdPtr <= '0;
            wrPtr <= '0;
            count <= '0;
        end else begin
            rdPtr <= next_rdPtr;
            wrPtr <= next_wrPtr;
            count <= next_count;
        end
        if (push) begin
            mem[wrPtr] <= inData;
        end else if (over) begin
            // newest word lost to the fresh one
            mem[(wrPtr == '0) ? PW'(DEPTH - 1) : PW'(wrPtr - 1'b1)] <= inData;
        end
    end
endmodule

module ips_audio_port
    import ips_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic sysRst, // synchronous reset
    input wire logic portOn, // link enable
    input wire logic masterOn, // role select, 1 master
    input wire logic txSingleChannel, // transmit mono
    input wire logic rxSingleChannel, // receive mono
    input wire logic lawExpandOn, // expand written bytes
    input wire logic lawCompressOn, // compress received words
    input wire logic [ips_pkg::SIZE_W-1:0] wordSizeM1, // master word size minus one
    input wire logic [ips_pkg::BYTE_W-1:0] dividerRegFirst, // divisor low bits
    input wire logic [ips_pkg::BYTE_W-1:0] dividerRegSecond, // dividend low bits
    input wire logic [ips_pkg::BYTE_W-1:0] dividerRegThird, // dividend high, divisor top
    input wire logic txDoneIrqOn, // local transmit irq enable
    input wire logic rxDoneIrqOn, // local receive irq enable
    input wire logic sysTxIrqOn, // system transmit irq enable
    input wire logic sysRxIrqOn, // system receive irq enable
    input wire logic sampleLowWr, // low data byte write
    input wire logic sampleHighWr, // high data byte write
    input wire logic [ips_pkg::BYTE_W-1:0] wrData, // write byte
    output logic writeReady, // high write will be taken
    input wire logic sampleHighRd, // high data byte read
    output logic [ips_pkg::BYTE_W-1:0] sampleHighByte, // readable high byte
    output logic [ips_pkg::BYTE_W-1:0] sampleLowByte, // readable low byte
    input wire logic setTxDone, // software sets transmit done
    input wire logic setRxDone, // software sets receive done
    input wire logic clrTxUnderflow, // software clears underflow
    input wire logic clrRxOverflow, // software clears overflow
    input wire logic clrSysTxIrq, // clears system transmit flag
    input wire logic clrSysRxIrq, // clears system receive flag
    output logic txDoneFlag, // transmit complete
    output logic rxDoneFlag, // receive complete
    output logic txUnderflowFlag, // transmit underflow
    output logic rxOverflowFlag, // receive overflow
    output logic sysTxIrqFlag, // system transmit flag
    output logic sysRxIrqFlag, // system receive flag
    output logic tx_done_flag, // transmit interrupt request
    output logic rx_done_flag, // receive interrupt request
    output logic txDmaTrigger, // transmit dma pulse
    output logic rxDmaTrigger, // receive dma pulse
    output logic txChannelSide, // next write is right
    output logic rxChannelSide, // held sample is right
    input wire logic sckIn, // serial clock pin in
    output logic sckOut, // serial clock pin out
    output logic sckDriveN, // low while driving clock
    input wire logic wsIn, // word select pin in
    output logic wsOut, // word select pin out
    output logic wsDriveN, // low while driving word select
    input wire logic rxd, // serial data in
    output logic txd // serial data out
);
    // ---- divider and link framing
    logic sckReg, next_sckReg, wsReg, next_wsReg, sckPrev, next_sckPrev;
    logic wsAtRise, next_wsAtRise, newWordPend, next_newWordPend;
    logic [NUM_W-1:0] acc, next_acc, dividend;
    logic [DEN_W-1:0] divisor;
    logic [NUM_W:0] accSum;
    ips_link_type link, next_link;
    logic [DATA_W-1:0] txShift, next_txShift, txHold, next_txHold;
    logic [DATA_W-1:0] rxShift, next_rxShift, rxWord;
    logic [CNT_W-1:0] txCnt, next_txCnt, rxCnt, next_rxCnt;
    logic txdReg, next_txdReg;
    logic sckLine, wsLine, rise, fall, run;
    logic txPop, txUnder, rxPush;
    ips_sample_type txIn, txOut, rxIn, rxOut;
    logic txFifoValid, txFifoReady, rxFifoValid, rxFifoReady, rxTake;
    // ---- data registers and flags
    logic [BYTE_W-1:0] lowLatch, next_lowLatch;
    logic [DATA_W-1:0] stage, next_stage, rdWord, next_rdWord;
    logic stageValid, next_stageValid, rdFull, next_rdFull;
    logic next_txDone, next_rxDone, next_under, next_over, next_sysTx, next_sysRx;
    logic next_txSide, next_rxSide, next_txDma, next_rxDma, hiWrTaken;

    assign dividend = {dividerRegThird[DIV_NUM_HI_MSB:0], dividerRegSecond};
    assign divisor = {dividerRegThird[DIV_DEN_HI_BIT], dividerRegFirst};
    assign run = portOn;
    assign sckLine = masterOn ? sckReg : sckIn;
    assign wsLine = masterOn ? wsReg : wsIn;
    assign rise = run && sckLine && !sckPrev;
    assign fall = run && !sckLine && sckPrev;
    assign sckOut = sckReg;
    assign wsOut = wsReg;
    assign sckDriveN = !masterOn;
    assign wsDriveN = !masterOn;
    assign txd = txdReg;

    function automatic logic [DATA_W-1:0] align(input logic [DATA_W-1:0] v,
                                                input logic [CNT_W-1:0] n);
        // short words are left-justified, long ones already truncated
        return (n >= CNT_FULL) ? v : DATA_W'(v << (CNT_FULL - n));
    endfunction

    always_comb begin
        next_acc = acc;
        next_sckReg = sckReg;
        accSum = (NUM_W + 1)'(acc) + (NUM_W + 1)'(divisor);
        if (run && masterOn) begin
            // toggles on average once per dividend/divisor clocks
            if (accSum >= (NUM_W + 1)'(dividend)) begin
                next_acc = NUM_W'(accSum - (NUM_W + 1)'(dividend));
                next_sckReg = !sckReg;
            end else begin
                next_acc = NUM_W'(accSum);
            end
        end else begin
            next_acc = '0;
            next_sckReg = 1'b0;
        end
        next_sckPrev = run ? sckLine : 1'b0;
        next_wsReg = wsReg;
        next_wsAtRise = wsAtRise;
        next_newWordPend = newWordPend;
        next_link = link;
        next_txShift = txShift;
        next_txHold = txHold;
        next_txCnt = txCnt;
        next_txdReg = txdReg;
        next_rxShift = rxShift;
        next_rxCnt = rxCnt;
        rxWord = WORD_ZERO;
        rxPush = 1'b0;
        txPop = 1'b0;
        txUnder = 1'b0;
        if (!run) begin
            next_link = LINK_IDLE;
            next_wsReg = 1'b1;
            next_newWordPend = 1'b0;
            next_txdReg = 1'b0;
        end else begin
            if (rise) begin
                if (rxCnt < CNT_FULL) begin
                    next_rxShift = {rxShift[DATA_W-2:0], rxd};
                end
                next_rxCnt = (rxCnt == '1) ? rxCnt : CNT_W'(rxCnt + CNT_ONE);
                next_wsAtRise = wsLine;
                if (link == LINK_IDLE) begin
                    next_link = LINK_SYNC;
                end else if (wsLine != wsAtRise) begin
                    // edge seen on the last bit of the word: close it
                    if (link == LINK_RUN && !(rxSingleChannel && wsAtRise)) begin
                        rxPush = 1'b1;
                        rxWord = align(next_rxShift, next_rxCnt);
                    end
                    next_link = LINK_RUN;
                    next_newWordPend = 1'b1;
                    next_rxCnt = '0;
                    next_rxShift = WORD_ZERO;
                end
            end
            if (fall) begin
                if (newWordPend) begin
                    next_newWordPend = 1'b0;
                    if (!(txSingleChannel && wsLine)) begin
                        if (txFifoValid) begin
                            txPop = 1'b1;
                            next_txHold = txOut.data;
                        end else begin
                            txUnder = 1'b1;
                        end
                    end
                    next_txdReg = next_txHold[DATA_W-1];
                    next_txShift = {next_txHold[DATA_W-2:0], 1'b0};
                    next_txCnt = CNT_ONE;
                end else begin
                    // zeros shift in: pads words longer than the register
                    next_txdReg = txShift[DATA_W-1];
                    next_txShift = {txShift[DATA_W-2:0], 1'b0};
                    next_txCnt = (txCnt == '1) ? txCnt : CNT_W'(txCnt + CNT_ONE);
                end
                if (masterOn) begin
                    if (link == LINK_SYNC && wsReg) begin
                        next_wsReg = 1'b0; // first word is left
                    end else if (link == LINK_RUN &&
                                 next_txCnt == CNT_W'(wordSizeM1) + CNT_ONE) begin
                        next_wsReg = !wsReg;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sysRst) begin
            acc <= '0;
            sckReg <= 1'b0;
            sckPrev <= 1'b0;
            wsReg <= 1'b1;
            wsAtRise <= 1'b1;
            newWordPend <= 1'b0;
            link <= LINK_IDLE;
            txShift <= WORD_ZERO;
            txHold <= WORD_ZERO;
            txCnt <= '0;
            txdReg <= 1'b0;
            rxShift <= WORD_ZERO;
            rxCnt <= '0;
        end else begin
            acc <= next_acc;
            sckReg <= next_sckReg;
            sckPrev <= next_sckPrev;
            wsReg <= next_wsReg;
            wsAtRise <= next_wsAtRise;
            newWordPend <= next_newWordPend;
            link <= next_link;
            txShift <= next_txShift;
            txHold <= next_txHold;
            txCnt <= next_txCnt;
            txdReg <= next_txdReg;
            rxShift <= next_rxShift;
            rxCnt <= next_rxCnt;
        end
    end

    // two-entry buffers between the data registers and the serializers
    assign txIn = '{chan: 1'b0, data: stage};
    assign rxIn = '{chan: wsAtRise, data: rxWord};
    assign rxTake = !rdFull;

    ips_fifo2 #(.W($bits(ips_sample_type)), .DEPTH(BUF_DEPTH)) txBuf (
        .clk(clk),
        .sysRst(sysRst || !run),
        .inValid(stageValid),
        .inReady(txFifoReady),
        .inForce(1'b0),
        .inData(txIn),
        .outValid(txFifoValid),
        .outReady(txPop),
        .outData(txOut)
    );

    ips_fifo2 #(.W($bits(ips_sample_type)), .DEPTH(BUF_DEPTH)) rxBuf (
        .clk(clk),
        .sysRst(sysRst || !run),
        .inValid(rxPush),
        .inReady(rxFifoReady),
        .inForce(1'b1),
        .inData(rxIn),
        .outValid(rxFifoValid),
        .outReady(rxTake),
        .outData(rxOut)
    );

    assign writeReady = !stageValid || !run;
    assign hiWrTaken = sampleHighWr && writeReady;

    always_comb begin
        next_lowLatch = sampleLowWr ? wrData : lowLatch;
        next_stage = stage;
        next_stageValid = stageValid && !txFifoReady;
        next_rdWord = rdWord;
        next_rdFull = rdFull && !sampleHighRd;
        next_rxSide = rxChannelSide;
        next_txSide = txChannelSide;
        if (hiWrTaken && run) begin
            next_stage = lawExpandOn ? ips_expand(wrData) : {wrData, lowLatch};
            next_stageValid = 1'b1;
            if (!txSingleChannel) begin
                next_txSide = !txChannelSide;
            end
        end else if (hiWrTaken) begin
            // port off: one-cycle stand-alone conversion
            if (lawExpandOn) begin
                next_rdWord = ips_expand(wrData);
            end else if (lawCompressOn) begin
                next_rdWord = {ips_compress({wrData, lowLatch}), BYTE_ZERO};
            end else begin
                next_rdWord = {wrData, lowLatch};
            end
        end
        if (!run) begin
            next_txSide = 1'b0;
        end
        if (rxFifoValid && rxTake) begin
            next_rdWord = lawCompressOn ? {ips_compress(rxOut.data), BYTE_ZERO}
                                        : rxOut.data;
            next_rdFull = 1'b1;
            next_rxSide = rxOut.chan;
        end
        next_txDma = txPop;
        next_rxDma = rxFifoValid && rxTake;
        // a setting event wins over a clear in the same cycle
        next_txDone = txPop || setTxDone || (txDoneFlag && !sampleHighWr);
        next_rxDone = next_rxDma || setRxDone || (rxDoneFlag && !sampleHighRd);
        next_sysTx = txPop || (sysTxIrqFlag && !clrSysTxIrq);
        next_sysRx = next_rxDma || (sysRxIrqFlag && !clrSysRxIrq);
        next_under = txUnder || (txUnderflowFlag && !clrTxUnderflow);
        next_over = (rxPush && !rxFifoReady) || (rxOverflowFlag && !clrRxOverflow);
    end

    always_ff @(posedge clk) begin
        if (sysRst) begin
            lowLatch <= BYTE_ZERO;
            stage <= WORD_ZERO;
            stageValid <= 1'b0;
            rdWord <= WORD_ZERO;
            rdFull <= 1'b0;
            txDoneFlag <= 1'b0;
            rxDoneFlag <= 1'b0;
            sysTxIrqFlag <= 1'b0;
            sysRxIrqFlag <= 1'b0;
            txUnderflowFlag <= 1'b0;
            rxOverflowFlag <= 1'b0;
            txDmaTrigger <= 1'b0;
            rxDmaTrigger <= 1'b0;
            txChannelSide <= 1'b0;
            rxChannelSide <= 1'b0;
        end else begin
            lowLatch <= next_lowLatch;
            stage <= next_stage;
            stageValid <= next_stageValid;
            rdWord <= next_rdWord;
            rdFull <= next_rdFull;
            txDoneFlag <= next_txDone;
            rxDoneFlag <= next_rxDone;
            sysTxIrqFlag <= next_sysTx;
            sysRxIrqFlag <= next_sysRx;
            txUnderflowFlag <= next_under;
            rxOverflowFlag <= next_over;
            txDmaTrigger <= next_txDma;
            rxDmaTrigger <= next_rxDma;
            txChannelSide <= next_txSide;
            rxChannelSide <= next_rxSide;
        end
    end

    assign sampleHighByte = rdWord[DATA_W-1:BYTE_W];
    assign sampleLowByte = rdWord[BYTE_W-1:0];
    assign tx_done_flag = txDoneFlag && txDoneIrqOn && sysTxIrqOn;
    assign rx_done_flag = rxDoneFlag && rxDoneIrqOn && sysRxIrqOn;
endmodule

`default_nettype wire

// ===== inc/ips_pkg.sv
// shared constants, types and sample arithmetic for the serial audio port
package ips_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_FULL = 6'h10;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam int SIZE_W = 5;
    localparam int NUM_W = 15;
    localparam int DEN_W = 9;
    localparam int DIV_NUM_HI_MSB = 6;
    localparam int DIV_DEN_HI_BIT = 7;
    localparam logic [DATA_W-1:0] ULAW_BIAS = 16'h0084;
    localparam logic [DATA_W-1:0] ULAW_CLIP = 16'h7F7B;
    localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam int ULAW_SEG_LSB = 7;
    localparam int ULAW_MANT_SHIFT = 3;
    localparam int RX_DMA_TRIGGER_NUM = 27;
    localparam int TX_DMA_TRIGGER_NUM = 28;
    localparam int BUF_DEPTH = 2;

    typedef struct packed {
        logic chan;
        logic [DATA_W-1:0] data;
    } ips_sample_type;

    typedef enum logic [1:0] {LINK_IDLE, LINK_SYNC, LINK_RUN} ips_link_type;

    function automatic logic [DATA_W-1:0] ips_expand(input logic [BYTE_W-1:0] b);
        logic [BYTE_W-1:0] u;
        logic [DATA_W-1:0] t;
        u = ~b;
        t = 16'({u[3:0], 3'b000} + ULAW_BIAS);
        t = 16'(t << u[6:4]);
        t = 16'(t - ULAW_BIAS);
        return u[7] ? 16'(~t + 16'h0001) : t;
    endfunction

    function automatic logic [BYTE_W-1:0] ips_compress(input logic [DATA_W-1:0] s);
        logic [DATA_W-1:0] mag;
        logic [2:0] e;
        logic [3:0] m;
        mag = s[15] ? 16'(~s + 16'h0001) : s;
        if (mag > ULAW_CLIP) begin
            mag = ULAW_CLIP;
        end
        mag = 16'(mag + ULAW_BIAS);
        e = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (mag[ULAW_SEG_LSB + i]) begin
                e = 3'(i);
            end
        end
        m = 4'(mag >> (e + ULAW_MANT_SHIFT));
        return ~{s[15], e, m};
    endfunction
endpackage

// ===== verification/ips_audio_port_properties.sv
// assertions and covers watching the serial audio port pins
`timescale 1ns/10ps
`default_nettype none
module ips_audio_port_properties (
    input wire logic clk, // clock
    input wire logic sysRst, // reset
    input wire logic masterOn, // role
    input wire logic txDoneIrqOn, // enable
    input wire logic rxDoneIrqOn, // enable
    input wire logic sysTxIrqOn, // enable
    input wire logic sysRxIrqOn, // enable
    input wire logic sampleHighWr, // write
    input wire logic sampleHighRd, // read
    input wire logic setTxDone, // set
    input wire logic setRxDone, // set
    input wire logic clrTxUnderflow, // clear
    input wire logic clrRxOverflow, // clear
    input wire logic txDoneFlag, // flag
    input wire logic rxDoneFlag, // flag
    input wire logic txUnderflowFlag, // flag
    input wire logic rxOverflowFlag, // flag
    input wire logic sysTxIrqFlag, // flag
    input wire logic sysRxIrqFlag, // flag
    input wire logic tx_done_flag, // request
    input wire logic rx_done_flag, // request
    input wire logic txDmaTrigger, // pulse
    input wire logic rxDmaTrigger, // pulse
    input wire logic sckDriveN, // enable low
    input wire logic wsDriveN // enable low
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sysRst);
    chk_tx_irq_gate: assert property (tx_done_flag == (txDoneFlag && txDoneIrqOn && sysTxIrqOn))
        else $error("tx request not gated by both enables");
    chk_rx_irq_gate: assert property (rx_done_flag == (rxDoneFlag && rxDoneIrqOn && sysRxIrqOn))
        else $error("rx request not gated by both enables");
    chk_pin_drive_role: assert property (sckDriveN == !masterOn && wsDriveN == !masterOn)
        else $error("pin drive does not follow role");
    chk_tx_dma_event: assert property (txDmaTrigger |-> txDoneFlag && sysTxIrqFlag ##1 !txDmaTrigger)
        else $error("tx trigger without flags or too long");
    chk_rx_dma_event: assert property (rxDmaTrigger |-> rxDoneFlag && sysRxIrqFlag ##1 !rxDmaTrigger)
        else $error("rx trigger without flags or too long");
    chk_tx_write_clear: assert property (sampleHighWr && !setTxDone |=> !txDoneFlag || txDmaTrigger)
        else $error("high write left tx done set");
    chk_rx_read_clear: assert property (sampleHighRd && !setRxDone |=> !rxDoneFlag || rxDmaTrigger)
        else $error("high read left rx done set");
    chk_unf_sticky: assert property (txUnderflowFlag && !clrTxUnderflow |=> txUnderflowFlag)
        else $error("underflow cleared by itself");
    chk_ovf_sticky: assert property (rxOverflowFlag && !clrRxOverflow |=> rxOverflowFlag)
        else $error("overflow cleared by itself");
    cover property (txDmaTrigger);
    cover property (rxDmaTrigger);
    cover property ($rose(txUnderflowFlag));
endmodule
`default_nettype wire

// ===== verification/ips_codec_model.sv
// behavioural slave codec on the far side of the serial link
`timescale 1ns/10ps
`default_nettype none
module ips_codec_model
    import ips_pkg::*;
(
    input wire logic sck, // serial clock
    input wire logic ws, // word select
    input wire logic txd, // data from port
    output logic rxd, // data to port
    input wire logic [ips_pkg::DATA_W-1:0] sendWord, // word sent
    output logic [ips_pkg::DATA_W-1:0] heardWord, // last word heard
    output int heardCount // words heard
);
    logic [DATA_W-1:0] inSh = '0;
    logic [DATA_W-1:0] outSh = 16'h5555;
    logic wsPrev = 1'b1;
    initial begin
        rxd = 1'b0;
        heardWord = '0;
        heardCount = 0;
    end
    // ws change seen at a rise marks the last bit
    // msb first on the fall; past the word the line shows inverted bits
    always @(sck) begin
        if (sck === 1'b1) begin
            inSh <= {inSh[14:0], txd};
            wsPrev <= ws;
            if (ws != wsPrev) begin
                heardWord <= {inSh[14:0], txd};
                heardCount <= heardCount + 1;
                outSh <= sendWord;
            end
        end else if (sck === 1'b0) begin
            rxd <= outSh[15];
            outSh <= {outSh[14:0], ~outSh[15]};
        end
    end
endmodule
`default_nettype wire

// ===== verification/tb_ips_audio_port.sv
// testbench for the serial audio port
`timescale 1ns/10ps
`default_nettype none
module tb_ips_audio_port
    import ips_pkg::*;
;
    logic clk = 1'b0, sysRst = 1'b1, portOn = 0, masterOn = 0, txSingleChannel = 0;
    logic rxSingleChannel = 0, lawExpandOn = 0, lawCompressOn = 0, txDoneIrqOn = 0;
    logic rxDoneIrqOn = 0, sysTxIrqOn = 0, sysRxIrqOn = 0, sampleLowWr = 0, sampleHighWr = 0;
    logic sampleHighRd = 0, setTxDone = 0, setRxDone = 0, clrTxUnderflow = 0, clrRxOverflow = 0;
    logic clrSysTxIrq = 0, clrSysRxIrq = 0;
    logic [SIZE_W-1:0] wordSizeM1 = 5'h0f;
    logic [BYTE_W-1:0] dividerRegFirst = 8'h00, dividerRegSecond = 8'h00, dividerRegThird = 8'h00;
    logic [BYTE_W-1:0] wrData = 8'h00, sampleHighByte, sampleLowByte;
    logic writeReady, txDoneFlag, rxDoneFlag, txUnderflowFlag, rxOverflowFlag, sysTxIrqFlag;
    logic sysRxIrqFlag, tx_done_flag, rx_done_flag, txDmaTrigger, rxDmaTrigger, txChannelSide, rxChannelSide;
    logic sckOut, sckDriveN, wsOut, wsDriveN, rxd, txd;
    logic [DATA_W-1:0] heardWord, w;
    int heardCount, badCount = 0, nTests = 0, txPops = 0, n, nWr = 0;
    // released pins fall back to their pull levels
    wire logic sckIn = sckDriveN ? 1'b0 : sckOut;
    wire logic wsIn = wsDriveN ? 1'b1 : wsOut;
    ips_audio_port dut_u (.*);
    ips_codec_model codec_u (.sck(sckIn), .ws(wsIn), .txd(txd), .rxd(rxd),
        .sendWord(16'hA5C3), .heardWord(heardWord), .heardCount(heardCount));
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (txDmaTrigger === 1'b1) begin
            txPops++;
        end
        if (sampleHighWr && portOn) nWr++;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic writeWord(input logic [15:0] v);
        @(posedge clk);
        sampleLowWr <= 1'b1;
        wrData <= v[7:0];
        @(posedge clk);
        sampleLowWr <= 1'b0;
        sampleHighWr <= 1'b1;
        wrData <= v[15:8];
        @(posedge clk);
        sampleHighWr <= 1'b0;
    endtask
    task automatic readWord(output logic [15:0] v);
        @(negedge clk);
        v = {sampleHighByte, sampleLowByte};
        @(posedge clk);
        sampleHighRd <= 1'b1;
        @(posedge clk);
        sampleHighRd <= 1'b0;
    endtask
    task automatic completeRun;
        $display("checks %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        completeRun;
    end
    initial begin
        repeat (16) @(posedge clk);
        sysRst <= 1'b0;
        @(negedge clk);
        check("reset flags", 16'({txDoneFlag, rxDoneFlag, txUnderflowFlag, rxOverflowFlag}), 0);
        check("reset pins", 16'({sckOut, wsOut, writeReady, sckDriveN}), 16'h0007);
        $display("test reset done");
        @(posedge clk);
        lawExpandOn <= 1'b1;
        writeWord(16'h0000);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("expand", {sampleHighByte, sampleLowByte}, 16'h8284);
        @(posedge clk);
        lawExpandOn <= 1'b0;
        lawCompressOn <= 1'b1;
        writeWord(16'h8284);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("compress", 16'(sampleHighByte), 16'h0000);
        $display("test law done");
        @(posedge clk);
        lawCompressOn <= 1'b0;
        {setTxDone, setRxDone, txDoneIrqOn, sysTxIrqOn, rxDoneIrqOn, sysRxIrqOn} <= 6'h3f;
        @(posedge clk);
        {setTxDone, setRxDone} <= 2'b00;
        @(negedge clk);
        check("soft irq", 16'({tx_done_flag, rx_done_flag, sysTxIrqFlag}), 16'h0006);
        @(posedge clk);
        sysTxIrqOn <= 1'b0;
        rxDoneIrqOn <= 1'b0;
        @(negedge clk);
        check("masked irq", 16'({tx_done_flag, rx_done_flag, txDoneFlag}), 16'h0001);
        writeWord(16'h1234);
        readWord(w);
        @(negedge clk);
        check("done cleared", 16'({txDoneFlag, rxDoneFlag}), 16'h0000);
        $display("test flags done");
        @(posedge clk);
        {dividerRegFirst, dividerRegSecond} <= 16'h0104;
        {sysTxIrqOn, rxDoneIrqOn, clrSysTxIrq, clrSysRxIrq} <= 4'hc;
        @(posedge clk);
        {masterOn, clrSysTxIrq, clrSysRxIrq} <= 3'b100; // divider set first
        @(posedge clk);
        portOn <= 1'b1;
        @(negedge clk);
        check("master pins", 16'({sckDriveN, wsDriveN}), 16'h0000);
        while (heardCount < 8) begin
            @(negedge clk);
            if (writeReady === 1'b1) writeWord(16'h9C35);
        end
        check("tx word", heardWord, 16'h9C35);
        check("tx pops", 16'(txPops > 3), 16'h0001);
        check("rx overflow", 16'({rxDoneFlag, rxOverflowFlag, rxChannelSide}), 16'h0006);
        readWord(w);
        check("rx word", w, 16'hA5C3);
        $display("test link done");
        n = heardCount;
        while (heardCount < n + 4) @(negedge clk);
        check("underflow", 16'({txUnderflowFlag, rxChannelSide}), 16'h0003);
        check("stale word", heardWord, 16'h9C35);
        check("tx side", 16'(txChannelSide), 16'(nWr % 2));
        @(posedge clk);
        portOn <= 1'b0;
        @(posedge clk);
        {clrTxUnderflow, clrRxOverflow} <= 2'b11;
        @(posedge clk);
        {clrTxUnderflow, clrRxOverflow} <= 2'b00;
        @(negedge clk);
        check("errors cleared", 16'({txUnderflowFlag, rxOverflowFlag}), 16'h0000);
        $display("test underflow done");
        completeRun;
    end
endmodule
bind ips_audio_port ips_audio_port_properties chk_u (.*);
`default_nettype wire
